//--- hdl/jimc_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the id and monitor block
// Assumes: 200 MHz clock
// Notes:   times are kept in their own units; cycle counts derive from them
`ifndef JIMC_MAP_SVH
`define JIMC_MAP_SVH
`define JIMC_CLK_MHZ         200
`define JIMC_PDU2_DIGIT      4'hf
`define JIMC_GLOBAL_ADDR     8'hff
`define JIMC_SA_DEFAULT      8'hf9
`define JIMC_PRIO_PAGE_RST   5'h18
`define JIMC_HDR_PF_RST      8'hea
`define JIMC_HDR_PS_RST      8'hff
`define JIMC_PROTO_A         4'ha
`define JIMC_PROTO_B         4'hb
`define JIMC_PROTO_C         4'hc
`define JIMC_J1939_OPTIONS   8'h42
`define JIMC_DIV_BASE_KBPS   500
`define JIMC_PROTO_A_KBPS    250
`define JIMC_DIV_PROTO_A     8'((`JIMC_DIV_BASE_KBPS) / (`JIMC_PROTO_A_KBPS))
`define JIMC_AUTO_TO_MS      1250
`define JIMC_ST_UNIT_MS      4
`define JIMC_AUTO_TO_CYC     (`JIMC_AUTO_TO_MS * 1000 * `JIMC_CLK_MHZ)
`define JIMC_ST_UNIT_CYC     (`JIMC_ST_UNIT_MS * 1000 * `JIMC_CLK_MHZ)
`define JIMC_TMULT_FIVE      3'd5
`define JIMC_TMULT_ONE       3'd1
`define JIMC_PRIO_MSB        28
`define JIMC_PRIO_LSB        26
`define JIMC_EDP_POS         25
`define JIMC_DP_POS          24
`define JIMC_PF_MSB          23
`define JIMC_PF_LSB          16
`define JIMC_PS_MSB          15
`define JIMC_PS_LSB          8
`define JIMC_SA_MSB          7
`define JIMC_SA_LSB          0
`define JIMC_PGN_DM1         24'h00feca
`endif

//--- hdl/jimc_pkg.sv
// Purpose: types and decoding shared by the id and monitor block
// Assumes: 29-bit identifiers
// Notes:   field positions come from jimc_map.svh
`include "jimc_map.svh"
package jimc_pkg;
  typedef logic [28:0] jimc_id_t;
  typedef logic [23:0] jimc_pgn_t;
  typedef enum logic [1:0] {
    JIMC_MON_IDLE  = 2'b00,
    JIMC_MON_RUN   = 2'b01,
    JIMC_MON_DONE  = 2'b10
  } jimc_mon_t;

  function automatic logic jimc_is_pdu2(input jimc_id_t id);
    return id[`JIMC_PF_MSB -: 4] == `JIMC_PDU2_DIGIT;
  endfunction : jimc_is_pdu2

  function automatic jimc_pgn_t jimc_pgn_of(input jimc_id_t id);
    jimc_pgn_t p;
    p = {6'h00, id[`JIMC_EDP_POS:`JIMC_PF_LSB], id[`JIMC_PS_MSB:`JIMC_PS_LSB]};
    if (!jimc_is_pdu2(id)) begin
      p[7:0] = 8'h00;
    end
    return p;
  endfunction : jimc_pgn_of
endpackage : jimc_pkg

//--- hdl/jimc_fmt_if.sv
// Purpose: carries a received identifier to the display formatter and back
// Assumes: one clock domain
// Notes:   disp_valid follows id_valid by one cycle
interface jimc_fmt_if;
  import jimc_pkg::*;
  jimc_id_t    id;
  logic        id_valid;
  logic        format_on;
  logic [31:0] disp;
  logic        disp_valid;
  logic        pdu2;
  logic        glob_addr;
  modport core (output id, output id_valid, output format_on,
                input disp, input disp_valid, input pdu2, input glob_addr);
  modport fmt  (input id, input id_valid, input format_on,
                output disp, output disp_valid, output pdu2, output glob_addr);
endinterface : jimc_fmt_if

//--- hdl/jimc_id_fmt.sv
// Purpose: classifies a received identifier and lays it out for display
// Assumes: identifier is stable while id_valid is high
// Notes:   formatted layout is priority nibble, page nibble, then three bytes
`include "jimc_map.svh"
module jimc_id_fmt (
  input  wire logic clk,
  input  wire logic rst_n,
  jimc_fmt_if.fmt   f
);
  import jimc_pkg::*;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f.disp       <= 32'h0000_0000;
      f.disp_valid <= 1'b0;
      f.pdu2       <= 1'b0;
      f.glob_addr  <= 1'b0;
    end else begin
      f.disp_valid <= f.id_valid;
      if (f.id_valid) begin
        f.pdu2   <= jimc_is_pdu2(f.id);
        f.glob_addr <= !jimc_is_pdu2(f.id) && f.id[`JIMC_PS_MSB:`JIMC_PS_LSB] == `JIMC_GLOBAL_ADDR;
        if (f.format_on) begin
          // priority digit kept apart from the page digit
          f.disp <= {1'b0, f.id[`JIMC_PRIO_MSB:`JIMC_PRIO_LSB], 2'b00,
                     f.id[`JIMC_EDP_POS:`JIMC_DP_POS], f.id[`JIMC_PF_MSB:0]};
        end else begin
          f.disp <= {3'b000, f.id};
        end
      end
    end
  end
endmodule : jimc_id_fmt

//--- hdl/jimc_core.sv
// Purpose: builds and classifies 29-bit identifiers, picks rate and options, times
//          responses, and runs parameter-group monitoring for a diagnostic interpreter
// Assumes: command strobes are one-cycle pulses already parsed from host hex text
// Notes:   long counts are parameters so a simulation may shorten them
// How it works
// - PF upper digit F means broadcast PDU2
// - PDU1 destination FF means all devices
// - fixed source F9, changed by command only
// - priority-page setting resets to hex 18
// - identifier from four bytes or priority plus three
// - protocol A gives J1939 at 250 kbps
// - B/C J1939 when options 42, divisor 500k/rate
// - loaded options and divisor cleared by reset
// - automatic 1.25 s timeout unless manually set
// - x5 timer multiplier, restored by x1
// - trouble-code monitor runs until host character
// - silent by default; control 0 enables acknowledge
// - four-digit group gets 00 top byte
// - count digit limits whole messages, then prompt
// - identifier display hidden until switched on
// - formatting splits priority; off shows bytes
// - identifier is 3+2+8+8+8 bits
// - extended page bit always sent zero
`include "jimc_map.svh"
module jimc_core #(
  parameter int unsigned AUTO_TO_CYC = `JIMC_AUTO_TO_CYC,
  parameter int unsigned ST_UNIT_CYC = `JIMC_ST_UNIT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              protocol_select_cmd,
  input  wire logic [3:0]        protocol_code,
  input  wire logic              options_divisor_cmd,
  input  wire logic [7:0]        options_value,
  input  wire logic [7:0]        divisor_value,
  input  wire logic [7:0]        pp_options_b,
  input  wire logic [7:0]        pp_divisor_b,
  input  wire logic [7:0]        pp_options_c,
  input  wire logic [7:0]        pp_divisor_c,
  input  wire logic              header_setting_cmd,
  input  wire logic              header_four_bytes,
  input  wire logic [31:0]       header_bytes,
  input  wire logic              priority_page_setting_cmd,
  input  wire logic [4:0]        priority_page_value,
  input  wire logic              tester_address_cmd,
  input  wire logic [7:0]        tester_address_value,
  input  wire logic              response_timeout_setting,
  input  wire logic [7:0]        timeout_value,
  input  wire logic              timer_multiplier_five_cmd,
  input  wire logic              timer_multiplier_one_cmd,
  input  wire logic              silent_monitor_control,
  input  wire logic              silent_monitor_value,
  input  wire logic              header_display_on_cmd,
  input  wire logic              header_display_off_cmd,
  input  wire logic              j1939_header_format_on_cmd,
  input  wire logic              j1939_header_format_off_cmd,
  input  wire logic              group_monitor_cmd,
  input  wire logic              trouble_code_monitor_cmd,
  input  wire jimc_pkg::jimc_pgn_t group_digits,
  input  wire logic              group_six_digits,
  input  wire logic              count_given,
  input  wire logic [3:0]        count_digit,
  input  wire logic              host_char,
  input  wire logic              request_sent,
  input  wire logic              rx_valid,
  input  wire jimc_pkg::jimc_id_t rx_id,
  input  wire logic              rx_msg_end,
  output jimc_pkg::jimc_id_t     tx_id,
  output logic                   j1939_active,
  output logic [7:0]             rate_divisor,
  output logic                   ack_enable,
  output logic                   monitor_active,
  output jimc_pkg::jimc_pgn_t    monitor_pgn,
  output logic                   print_valid,
  output logic                   print_with_id,
  output logic                   print_formatted,
  output logic [31:0]            print_id,
  output logic                   rx_broadcast,
  output logic                   rx_global,
  output logic                   prompt,
  output logic                   response_timeout
);
  import jimc_pkg::*;
  jimc_fmt_if f ();
  jimc_id_fmt u_fmt (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (f)
  );

  logic [4:0]  prio_page;
  logic [7:0]  hdr_pf, hdr_ps, hdr_sa;
  logic [3:0]  hdr_top;
  logic [3:0]  proto;
  logic [7:0]  pb_options, pb_divisor;
  logic [7:0]  eff_options, eff_divisor;
  logic [7:0]  st_value;
  logic [2:0]  tmult;
  logic        hdr_four, pb_loaded, manual_to, show_id;
  logic        fmt_on, rx_hit, to_run, last_msg;
  jimc_mon_t   mon_state;
  logic [3:0]  mon_limit, mon_count;
  logic [31:0] to_count, to_base, to_load;

  // identifier settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_page <= `JIMC_PRIO_PAGE_RST;
      hdr_pf    <= `JIMC_HDR_PF_RST;
      hdr_ps    <= `JIMC_HDR_PS_RST;
      hdr_sa    <= `JIMC_SA_DEFAULT;
      hdr_top   <= 3'b000;
      hdr_four  <= 1'b0;
    end else begin
      if (priority_page_setting_cmd) begin
        prio_page <= priority_page_value;
        hdr_four  <= 1'b0;
      end
      if (header_setting_cmd) begin
        hdr_four <= header_four_bytes;
        hdr_pf   <= header_bytes[23:16];
        hdr_ps   <= header_bytes[15:8];
        hdr_sa   <= header_bytes[7:0];
        if (header_four_bytes) begin
          hdr_top <= {header_bytes[28:26], header_bytes[24]};
        end
      end else if (tester_address_cmd) begin
        hdr_sa <= tester_address_value;
      end
    end
  end
  // outgoing identifier, extended page forced low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_id <= {`JIMC_PRIO_PAGE_RST, `JIMC_HDR_PF_RST, `JIMC_HDR_PS_RST, `JIMC_SA_DEFAULT};
    end else if (hdr_four) begin
      tx_id <= {hdr_top[3:1], 1'b0, hdr_top[0], hdr_pf, hdr_ps, hdr_sa};
    end else begin
      tx_id <= {prio_page[4:2], 1'b0, prio_page[0], hdr_pf, hdr_ps, hdr_sa};
    end
  end
  // protocol, options and divisor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proto      <= 4'h0;
      pb_loaded  <= 1'b0;
      pb_options <= 8'h00;
      pb_divisor <= 8'h00;
    end else begin
      if (protocol_select_cmd) begin
        proto <= protocol_code;
      end
      if (options_divisor_cmd) begin
        pb_loaded  <= 1'b1;
        pb_options <= options_value;
        pb_divisor <= divisor_value;
      end
    end
  end

  always_comb begin
    eff_options = 8'h00;
    eff_divisor = 8'h00;
    if (pb_loaded) begin
      eff_options = pb_options;
      eff_divisor = pb_divisor;
    end else if (proto == `JIMC_PROTO_B) begin
      eff_options = pp_options_b;
      eff_divisor = pp_divisor_b;
    end else if (proto == `JIMC_PROTO_C) begin
      eff_options = pp_options_c;
      eff_divisor = pp_divisor_c;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      j1939_active <= 1'b0;
      rate_divisor <= 8'h00;
    end else if (proto == `JIMC_PROTO_A) begin
      j1939_active <= 1'b1;
      rate_divisor <= `JIMC_DIV_PROTO_A;
    end else if (proto == `JIMC_PROTO_B || proto == `JIMC_PROTO_C) begin
      j1939_active <= eff_options == `JIMC_J1939_OPTIONS;
      rate_divisor <= eff_divisor;
    end else begin
      j1939_active <= 1'b0;
      rate_divisor <= 8'h00;
    end
  end
  // display and acknowledge controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      show_id    <= 1'b0;
      fmt_on     <= 1'b1;
      ack_enable <= 1'b0;
    end else begin
      if (header_display_on_cmd) begin
        show_id <= 1'b1;
      end else if (header_display_off_cmd) begin
        show_id <= 1'b0;
      end
      if (j1939_header_format_off_cmd) begin
        fmt_on <= 1'b0;
      end else if (j1939_header_format_on_cmd) begin
        fmt_on <= 1'b1;
      end
      if (silent_monitor_control) begin
        ack_enable <= !silent_monitor_value;
      end
    end
  end

  // response timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      manual_to <= 1'b0;
      st_value  <= 8'h00;
      tmult     <= `JIMC_TMULT_ONE;
    end else begin
      if (response_timeout_setting) begin
        manual_to <= 1'b1;
        st_value  <= timeout_value;
      end
      if (timer_multiplier_five_cmd) begin
        tmult <= `JIMC_TMULT_FIVE;
      end else if (timer_multiplier_one_cmd) begin
        tmult <= `JIMC_TMULT_ONE;
      end
    end
  end

  always_comb begin
    to_base = manual_to ? 32'(st_value) * 32'(ST_UNIT_CYC) : 32'(AUTO_TO_CYC);
    to_load = to_base * 32'(tmult);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_count         <= 32'h0000_0000;
      to_run           <= 1'b0;
      response_timeout <= 1'b0;
    end else begin
      response_timeout <= 1'b0;
      if (request_sent || (to_run && rx_hit)) begin
        to_count <= to_load;
        to_run   <= 1'b1;
      end else if (to_run) begin
        if (to_count <= 32'h0000_0001) begin
          to_run           <= 1'b0;
          response_timeout <= 1'b1;
        end else begin
          to_count <= to_count - 32'h0000_0001;
        end
      end
    end
  end
  // group monitor
  assign rx_hit   = rx_valid && monitor_active && jimc_pgn_of(rx_id) == monitor_pgn;
  assign last_msg = rx_hit && rx_msg_end && mon_limit != 4'h0 && mon_count + 4'h1 >= mon_limit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_state      <= JIMC_MON_IDLE;
      monitor_active <= 1'b0;
      monitor_pgn    <= 24'h000000;
      mon_limit      <= 4'h0;
      mon_count      <= 4'h0;
      prompt         <= 1'b0;
    end else begin
      prompt <= 1'b0;
      unique case (mon_state)
        JIMC_MON_IDLE: begin
          if (trouble_code_monitor_cmd) begin
            monitor_pgn    <= `JIMC_PGN_DM1;
            mon_limit      <= 4'h0;
            mon_count      <= 4'h0;
            monitor_active <= 1'b1;
            mon_state      <= JIMC_MON_RUN;
          end else if (group_monitor_cmd) begin
            monitor_pgn    <= group_six_digits ? group_digits : {8'h00, group_digits[15:0]};
            mon_limit      <= count_given ? count_digit : 4'h0;
            mon_count      <= 4'h0;
            monitor_active <= 1'b1;
            mon_state      <= JIMC_MON_RUN;
          end
        end
        JIMC_MON_RUN: begin
          if (host_char || last_msg) begin
            monitor_active <= 1'b0;
            mon_state      <= JIMC_MON_DONE;
          end else if (rx_hit && rx_msg_end) begin
            mon_count <= mon_count + 4'h1;
          end
        end
        JIMC_MON_DONE: begin
          prompt    <= 1'b1;
          mon_state <= JIMC_MON_IDLE;
        end
        default: begin
          monitor_active <= 1'b0;
          mon_state      <= JIMC_MON_IDLE;
        end
      endcase
    end
  end

  // received identifier handed to the formatter
  assign f.id        = rx_id;
  assign f.id_valid  = rx_hit;
  assign f.format_on = fmt_on;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      print_valid     <= 1'b0;
      print_with_id   <= 1'b0;
      print_formatted <= 1'b1;
      print_id        <= 32'h0000_0000;
      rx_broadcast    <= 1'b0;
      rx_global       <= 1'b0;
    end else begin
      print_valid <= f.disp_valid;
      if (f.disp_valid) begin
        print_with_id   <= show_id;
        print_formatted <= fmt_on;
        print_id        <= show_id ? f.disp : 32'h0000_0000;
        rx_broadcast    <= f.pdu2;
        rx_global       <= f.glob_addr;
      end
    end
  end
endmodule : jimc_core

//--- sim/jimc_core_chk.sv
// Purpose: concurrent checks on the ports of the id and monitor block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to the block from the bench top file
module jimc_core_chk (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                protocol_select_cmd,
  input wire logic [3:0]          protocol_code,
  input wire logic                header_setting_cmd,
  input wire logic                tester_address_cmd,
  input wire logic [7:0]          tester_address_value,
  input wire logic                silent_monitor_control,
  input wire logic                silent_monitor_value,
  input wire logic                group_monitor_cmd,
  input wire logic                trouble_code_monitor_cmd,
  input wire logic                host_char,
  input wire jimc_pkg::jimc_id_t  rx_id,
  input wire jimc_pkg::jimc_id_t  tx_id,
  input wire logic                j1939_active,
  input wire logic [7:0]          rate_divisor,
  input wire logic                ack_enable,
  input wire logic                monitor_active,
  input wire jimc_pkg::jimc_pgn_t monitor_pgn,
  input wire logic                print_valid,
  input wire logic                rx_broadcast,
  input wire logic                rx_global,
  input wire logic                prompt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // monitor drops, then prompt
  sequence s_stop;
    !monitor_active ##1 prompt;
  endsequence
  AST_HOST_END: assert property (host_char && monitor_active |=> s_stop)
    else $error("no stop on host character");
  AST_FELL: assert property ($fell(monitor_active) |=> prompt)
    else $error("no prompt after monitor end");
  AST_PROMPT: assert property (prompt |-> !$past(monitor_active) && $past(monitor_active, 2))
    else $error("prompt without monitor end");
  AST_MON_START: assert property ((group_monitor_cmd || trouble_code_monitor_cmd) && !monitor_active |=> monitor_active)
    else $error("monitor did not start");
  AST_DM1_PGN: assert property (trouble_code_monitor_cmd && !monitor_active |=> monitor_pgn == 24'h00feca)
    else $error("trouble code group wrong");
  AST_ACK: assert property (silent_monitor_control |=> ack_enable == !$past(silent_monitor_value))
    else $error("acknowledge enable wrong");
  AST_PROTO_A: assert property (protocol_select_cmd && protocol_code == 4'ha |-> ##2 j1939_active && rate_divisor == 8'h02)
    else $error("protocol a setup wrong");
  AST_ADDR: assert property (tester_address_cmd && !header_setting_cmd |-> ##2 tx_id[7:0] == $past(tester_address_value, 2))
    else $error("source address not taken");
  AST_EDP: assert property (tx_id[25] == 1'b0)
    else $error("extended page bit set");
  AST_BCAST: assert property (print_valid |-> rx_broadcast == ($past(rx_id[23:20], 2) == 4'hf))
    else $error("broadcast flag wrong");
  AST_GLOBAL: assert property (print_valid && !rx_broadcast |-> rx_global == ($past(rx_id[15:8], 2) == 8'hff))
    else $error("global flag wrong");
endmodule : jimc_core_chk

//--- sim/jimc_bus_node.sv
// Purpose: behavioural bus node feeding received frames to the block
// Assumes: one frame line per rx_valid pulse
// Notes:   broadcast spacing is scaled down to BCAST_GAP cycles
module jimc_bus_node import jimc_pkg::*; #(
  parameter int BCAST_GAP = 8
) (
  input  wire logic          clk,
  output jimc_pkg::jimc_id_t rx_id,
  output logic               rx_valid,
  output logic               rx_msg_end
);
  timeunit 1ns;
  timeprecision 1ps;
  time last_b = 0;
  initial begin
    rx_valid = 1'b0;
    rx_id = '0;
    rx_msg_end = 1'b0;
  end
  // one line per call; id lines show the inverse once released
  task automatic send(input jimc_id_t id, input logic last);
    if (id[23:20] == 4'hf) begin
      while ($time < last_b + BCAST_GAP * 5) @(posedge clk);
    end
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_msg_end <= last;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_msg_end <= 1'b0;
    if (id[23:20] == 4'hf) last_b = $time;
  endtask : send
endmodule : jimc_bus_node

//--- sim/tb_jimc_core.sv
// Purpose: self-checking bench for the id and monitor block
// Assumes: timer counts shortened to 20 and 4 cycles
// Notes:   command strobes sit in one vector
module tb_jimc_core;
  timeunit 1ns;
  timeprecision 1ps;
  import jimc_pkg::*;
  localparam int s_prot = 0, s_optd = 1, s_hdr = 2, s_prio = 3, s_addr = 4, s_tout = 5, s_x5 = 6, s_x1 = 7;
  localparam int s_sil = 8, s_don = 9, s_doff = 10, s_fon = 11, s_foff = 12, s_grp = 13, s_trb = 14;
  localparam int s_host = 15, s_req = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [16:0] stb = 17'h0;
  logic [3:0]  code = 4'h0, cnt = 4'h0;
  logic [7:0]  opt = 8'h0, dvs = 8'h0, pob = 8'h0, pdb = 8'h0, poc = 8'h0, pdc = 8'h0, addr = 8'h0, tval = 8'h0;
  logic        hdr4 = 1'b0, silv = 1'b1, six = 1'b0, cgiv = 1'b0;
  logic [31:0] hdr = 32'h0;
  logic [4:0]  prio = 5'h18;
  jimc_pgn_t   grp = 24'h0;
  logic        rx_valid, rx_msg_end, j1939_active, ack_enable, monitor_active, print_valid;
  logic        print_with_id, print_formatted, rx_broadcast, rx_global, prompt, response_timeout;
  jimc_id_t    rx_id, tx_id;
  logic [7:0]  rate_divisor;
  jimc_pgn_t   monitor_pgn;
  logic [31:0] print_id;
  int          errors = 0;
  int          n_checks = 0;
  jimc_core #(.AUTO_TO_CYC(20), .ST_UNIT_CYC(4)) i_dut (
    .clk, .rst_n, .protocol_select_cmd(stb[s_prot]), .protocol_code(code),
    .options_divisor_cmd(stb[s_optd]), .options_value(opt), .divisor_value(dvs),
    .pp_options_b(pob), .pp_divisor_b(pdb), .pp_options_c(poc), .pp_divisor_c(pdc),
    .header_setting_cmd(stb[s_hdr]), .header_four_bytes(hdr4), .header_bytes(hdr),
    .priority_page_setting_cmd(stb[s_prio]), .priority_page_value(prio),
    .tester_address_cmd(stb[s_addr]), .tester_address_value(addr),
    .response_timeout_setting(stb[s_tout]), .timeout_value(tval),
    .timer_multiplier_five_cmd(stb[s_x5]), .timer_multiplier_one_cmd(stb[s_x1]),
    .silent_monitor_control(stb[s_sil]), .silent_monitor_value(silv),
    .header_display_on_cmd(stb[s_don]), .header_display_off_cmd(stb[s_doff]),
    .j1939_header_format_on_cmd(stb[s_fon]), .j1939_header_format_off_cmd(stb[s_foff]),
    .group_monitor_cmd(stb[s_grp]), .trouble_code_monitor_cmd(stb[s_trb]), .group_digits(grp),
    .group_six_digits(six), .count_given(cgiv), .count_digit(cnt), .host_char(stb[s_host]),
    .request_sent(stb[s_req]), .rx_valid, .rx_id, .rx_msg_end, .tx_id, .j1939_active, .rate_divisor,
    .ack_enable, .monitor_active, .monitor_pgn, .print_valid, .print_with_id, .print_formatted,
    .print_id, .rx_broadcast, .rx_global, .prompt, .response_timeout);
  jimc_bus_node #(.BCAST_GAP(8)) i_node (.clk, .rx_id, .rx_valid, .rx_msg_end);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // strobe, then wait out the two-edge settings path
  task automatic cmd(input int b);
    @(posedge clk);
    stb[b] <= 1'b1;
    @(posedge clk);
    stb[b] <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : cmd
  task automatic stop(output logic [1:0] st);
    @(posedge clk) stb[s_host] <= 1'b1;
    @(posedge clk) stb[s_host] <= 1'b0;
    repeat (2) @(negedge clk);
    st = {monitor_active, prompt};
  endtask : stop
  task automatic do_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
  endtask : do_reset
  task automatic mon(input jimc_pgn_t g, input logic s, input logic [3:0] n);
    @(posedge clk) grp <= g;
    six <= s;
    cgiv <= (n != 4'h0);
    cnt <= n;
    cmd(s_grp);
  endtask : mon
  // node line, then bounded wait for its print
  task automatic frame(input jimc_id_t id, input logic last, output logic seen);
    i_node.send(id, last);
    seen = 1'b0;
    for (int k = 0; k < 5 && !seen; k++) begin
      @(negedge clk);
      seen = (print_valid === 1'b1);
    end
  endtask : frame
  task automatic measure(input int lo, input int hi);
    int n = 0;
    @(posedge clk);
    stb[s_req] <= 1'b1;
    @(posedge clk);
    stb[s_req] <= 1'b0;
    while (response_timeout !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("timeout", 32'(n >= lo && n <= hi), 32'h1);
  endtask : measure

  task automatic t_reset;
    chk("tx_rst", 32'(tx_id), 32'h18eafff9);
    chk("rate_rst", 32'({j1939_active, rate_divisor}), 32'h0);
    chk("ack_rst", 32'({ack_enable, monitor_active, print_with_id}), 32'h0);
    chk("fmt_rst", 32'(print_formatted), 32'h1);
  endtask : t_reset
  task automatic t_ids;
    @(posedge clk) prio <= 5'h1c;
    cmd(s_prio);
    chk("prio", 32'(tx_id[28:26]), 32'h7);
    @(posedge clk) hdr <= 32'h00fe0512;
    cmd(s_hdr);
    chk("tx3", 32'(tx_id), 32'h1cfe0512);
    @(posedge clk) addr <= 8'h33;
    cmd(s_addr);
    chk("addr", 32'(tx_id), 32'h1cfe0533);
    @(posedge clk) hdr4 <= 1'b1;
    hdr <= 32'h0bea0099;
    cmd(s_hdr);
    chk("tx4", 32'(tx_id), 32'h09ea0099);
    @(posedge clk) prio <= 5'h1a;
    cmd(s_prio);
    chk("edp", 32'(tx_id[28:24]), 32'h18);
  endtask : t_ids
  task automatic t_rates;
    @(posedge clk) poc <= 8'h42;
    pdc <= 8'h04;
    code <= 4'hc;
    cmd(s_prot);
    chk("c_pp", 32'({j1939_active, rate_divisor}), 32'h104);
    @(posedge clk) code <= 4'h6;
    cmd(s_prot);
    chk("other", 32'(j1939_active), 32'h0);
    @(posedge clk) code <= 4'ha;
    cmd(s_prot);
    chk("a", 32'({j1939_active, rate_divisor}), 32'h102);
    @(posedge clk) code <= 4'hb;
    cmd(s_prot);
    chk("b_off", 32'(j1939_active), 32'h0);
    @(posedge clk) opt <= 8'h42;
    dvs <= 8'h01;
    cmd(s_optd);
    cmd(s_prot);
    chk("b_load", 32'({j1939_active, rate_divisor}), 32'h101);
    do_reset;
    @(posedge clk) pob <= 8'h42;
    pdb <= 8'h02;
    cmd(s_prot);
    chk("b_kept", 32'({j1939_active, rate_divisor}), 32'h102);
  endtask : t_rates
  task automatic t_sil;
    @(posedge clk) silv <= 1'b0;
    cmd(s_sil);
    chk("ack", 32'(ack_enable), 32'h1);
    @(posedge clk) silv <= 1'b1;
    cmd(s_sil);
    chk("silent", 32'(ack_enable), 32'h0);
  endtask : t_sil
  task automatic t_mon;
    logic seen;
    logic [1:0] st;
    cmd(s_don);
    mon(24'h12feca, 1'b0, 4'h1);
    chk("pgn4", 32'(monitor_pgn), 32'h00feca);
    frame(29'h18feca00, 1'b1, seen);
    chk("fmt_on", print_id, 32'h60feca00);
    chk("end1", 32'({print_with_id, seen, rx_broadcast, rx_global, prompt, monitor_active}), 32'h3a);
    cmd(s_foff);
    mon(24'h00feca, 1'b1, 4'h1);
    frame(29'h18feca00, 1'b0, seen);
    chk("fmt_off", print_id, 32'h18feca00);
    chk("line", 32'({monitor_active, print_formatted}), 32'h2);
    frame(29'h18feca00, 1'b0, seen);
    frame(29'h18feca00, 1'b1, seen);
    chk("msg", 32'({monitor_active, prompt}), 32'h1);
    cmd(s_doff);
    cmd(s_fon);
    mon(24'h00feca, 1'b1, 4'h2);
    frame(29'h18feca00, 1'b1, seen);
    chk("hidden", print_id, 32'h0);
    chk("cnt2", 32'({print_with_id, monitor_active}), 32'h1);
    stop(st);
    chk("early", 32'(st), 32'h1);
    cmd(s_don);
    cmd(s_trb);
    chk("dm1", 32'({monitor_active, monitor_pgn}), 32'h100feca);
    repeat (3) frame(29'h18feca00, 1'b1, seen);
    frame(29'h18fecb00, 1'b1, seen);
    chk("dm1_run", 32'({seen, monitor_active}), 32'h1);
    stop(st);
    chk("dm1_end", 32'(st), 32'h1);
    mon(24'h00ea00, 1'b1, 4'h0);
    frame(29'h18eaff00, 1'b1, seen);
    chk("glob", 32'({seen, rx_broadcast, rx_global}), 32'h5);
    frame(29'h18ea0500, 1'b1, seen);
    chk("dest", 32'({seen, rx_broadcast, rx_global}), 32'h4);
    cmd(s_host);
  endtask : t_mon
  task automatic t_timer;
    measure(19, 24);
    cmd(s_x5);
    measure(99, 104);
    cmd(s_x1);
    measure(19, 24);
    @(posedge clk) tval <= 8'h03;
    cmd(s_tout);
    measure(11, 16);
  endtask : t_timer

  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    do_reset;
    t_reset;
    t_ids;
    t_rates;
    t_sil;
    t_mon;
    t_timer;
    report_and_stop;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule : tb_jimc_core

bind jimc_core jimc_core_chk i_chk (
  .clk, .rst_n, .protocol_select_cmd, .protocol_code, .header_setting_cmd, .tester_address_cmd,
  .tester_address_value, .silent_monitor_control, .silent_monitor_value, .group_monitor_cmd,
  .trouble_code_monitor_cmd, .host_char, .rx_id, .tx_id, .j1939_active, .rate_divisor, .ack_enable,
  .monitor_active, .monitor_pgn, .print_valid, .rx_broadcast, .rx_global, .prompt);
